// ===== design/qdac_ctrl_defs.vh
// Constants for the quad converter control register bank
`ifndef QDAC_CTRL_DEFS_VH
`define QDAC_CTRL_DEFS_VH

`define NUM_DAC            8
`define ADDR_W             8

// Register byte addresses
`define CTRL_BASE          8'h20
`define STAT_BASE          8'h40
`define TIMER_ADDR         8'h60
`define CTRL_SEL           3'h1
`define STAT_SEL           3'h2

// Control register fields
`define CTRL_W             10
`define CTRL_REQ_BIT       9
`define CTRL_GLM_BIT       8
`define CTRL_ASR_BIT       7
`define CTRL_SEQ_BIT       5
`define CTRL_ALERT_BIT     4
`define CTRL_LOAD_BIT      3
`define CTRL_MODE_HI       1
`define CTRL_MODE_LO       0
`define CTRL_RW_MASK       10'h1BB
`define CTRL_RESET         10'h000

// Operating modes
`define MODE_INSTANT       2'h0
`define MODE_MANUAL        2'h1
`define MODE_FIFO          2'h2
`define MODE_TIMER         2'h3

// Status register fields
`define STAT_DATA_W        10
`define STAT_VALID_BIT     10
`define STAT_W             11

// Auto status timer register
`define TIMER_W            16
`define TIMER_RESET        16'h03E8

// Timing
`define CLK_FREQ_MHZ       20
`define TICK_US            1
`define TICK_CYCLES        (`CLK_FREQ_MHZ * `TICK_US)
`define TICK_CNT_W         5
`define POST_UPDATE_US     10
`define POST_UPDATE_TICKS  (`POST_UPDATE_US / `TICK_US)

// AXI responses
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// ===== design/dac_channel.v
// One converter's control register, status register and status read scheduling
`timescale 1ns/1ps
`include "qdac_ctrl_defs.vh"

module dac_channel (
    input  wire                     clk_i,
    input  wire                     rst_n_i,
    input  wire                     tick_i,
    input  wire                     wr_en_i,
    input  wire [`CTRL_W-1:0]       wr_data_i,
    input  wire [`CTRL_W-1:0]       wr_mask_i,
    input  wire [`TIMER_W-1:0]      timer_period_i,
    input  wire                     update_i,
    input  wire                     status_done_i,
    input  wire [`STAT_DATA_W-1:0]  status_data_i,
    output reg  [`CTRL_W-1:0]       ctrl_o,
    output wire [`STAT_W-1:0]       status_o,
    output reg                      status_req_o
);

    reg  [`CTRL_W-1:0]      ctrl_next;
    reg  [`STAT_DATA_W-1:0] stat_data_reg;
    reg                     stat_valid_reg;
    reg  [`TIMER_W-1:0]     auto_cnt_reg;
    reg                     post_armed_reg;
    wire [1:0]              mode;
    wire [1:0]              new_mode;
    wire                    auto_status_read_enable;
    wire                    seq_mode;
    wire                    req_write;
    wire                    auto_fire;
    wire                    done_take;
    wire [`TIMER_W-1:0]     cnt_inc;
    wire [`TIMER_W-1:0]     period;

    assign mode     = ctrl_o[`CTRL_MODE_HI:`CTRL_MODE_LO];
    assign auto_status_read_enable      = ctrl_o[`CTRL_ASR_BIT];
    assign seq_mode = (mode == `MODE_FIFO) || (mode == `MODE_TIMER);
    assign cnt_inc  = auto_cnt_reg + 16'h0001;
    // A zero period is read as one tick, so it fires on every tick
    assign period   = (timer_period_i == 16'h0000) ? 16'h0001 : timer_period_i;

    always @*
    begin
        ctrl_next = ctrl_o;
        if (wr_en_i)
        begin
            // Request and reserved bits are never stored
            ctrl_next = (ctrl_o & ~wr_mask_i) | (wr_data_i & wr_mask_i & `CTRL_RW_MASK);
        end
    end

    assign new_mode  = ctrl_next[`CTRL_MODE_HI:`CTRL_MODE_LO];
    // Request honoured only in instant and manual modes
    assign req_write = wr_en_i && wr_mask_i[`CTRL_REQ_BIT] && wr_data_i[`CTRL_REQ_BIT]
                       && ((new_mode == `MODE_INSTANT) || (new_mode == `MODE_MANUAL));
    // Periodic in instant/manual, once after each update in FIFO/timer
    assign auto_fire = auto_status_read_enable && tick_i &&
                       (seq_mode ? (post_armed_reg && (cnt_inc >= `POST_UPDATE_TICKS))
                                 : (cnt_inc >= period));
    assign done_take = status_req_o && status_done_i;

    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ctrl_o         <= `CTRL_RESET;
            stat_data_reg  <= {`STAT_DATA_W{1'b0}};
            stat_valid_reg <= 1'b0;
            auto_cnt_reg   <= {`TIMER_W{1'b0}};
            post_armed_reg <= 1'b0;
            status_req_o   <= 1'b0;
        end
        else
        begin
            ctrl_o <= ctrl_next;
            if (!auto_status_read_enable)
            begin
                auto_cnt_reg   <= {`TIMER_W{1'b0}};
                post_armed_reg <= 1'b0;
            end
            else if (seq_mode)
            begin
                if (update_i)
                begin
                    post_armed_reg <= 1'b1;
                    auto_cnt_reg   <= {`TIMER_W{1'b0}};
                end
                else if (auto_fire)
                begin
                    post_armed_reg <= 1'b0;
                    auto_cnt_reg   <= {`TIMER_W{1'b0}};
                end
                else if (tick_i && post_armed_reg)
                begin
                    auto_cnt_reg <= cnt_inc;
                end
            end
            else if (tick_i)
            begin
                post_armed_reg <= 1'b0;
                auto_cnt_reg   <= auto_fire ? {`TIMER_W{1'b0}} : cnt_inc;
            end
            // A new request in the completion cycle stays pending
            if (req_write || auto_fire)
            begin
                status_req_o <= 1'b1;
            end
            else if (done_take)
            begin
                status_req_o <= 1'b0;
            end
            // Only a requested read may refresh the status
            if (done_take)
            begin
                stat_data_reg <= status_data_i;
            end
            if (req_write)
            begin
                stat_valid_reg <= 1'b0;
            end
            else if (done_take)
            begin
                stat_valid_reg <= 1'b1;
            end
        end
    end

    assign status_o = {stat_valid_reg, stat_data_reg};

endmodule

// ===== design/quad_dac_control_register.v
// Control register bank for up to eight quad converters, reached over AXI4-Lite
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "qdac_ctrl_defs.vh"

module quad_dac_control_register (
    input  wire                                 clk_i,
    input  wire                                 rst_n_i,
    input  wire [`ADDR_W-1:0]                   s_axi_awaddr_i,
    input  wire                                 s_axi_awvalid_i,
    output reg                                  s_axi_awready_o,
    input  wire [31:0]                          s_axi_wdata_i,
    input  wire [3:0]                           s_axi_wstrb_i,
    input  wire                                 s_axi_wvalid_i,
    output reg                                  s_axi_wready_o,
    output reg  [1:0]                           s_axi_bresp_o,
    output reg                                  s_axi_bvalid_o,
    input  wire                                 s_axi_bready_i,
    input  wire [`ADDR_W-1:0]                   s_axi_araddr_i,
    input  wire                                 s_axi_arvalid_i,
    output reg                                  s_axi_arready_o,
    output reg  [31:0]                          s_axi_rdata_o,
    output reg  [1:0]                           s_axi_rresp_o,
    output reg                                  s_axi_rvalid_o,
    input  wire                                 s_axi_rready_i,
    input  wire [`NUM_DAC-1:0]                  dac_update_i,
    input  wire [`NUM_DAC-1:0]                  transfer_done_i,
    input  wire [`NUM_DAC-1:0]                  status_done_i,
    input  wire [`NUM_DAC*`STAT_DATA_W-1:0]     status_data_i,
    input  wire [`NUM_DAC-1:0]                  seq_event_i,
    input  wire [`NUM_DAC-1:0]                  alert_event_i,
    input  wire [`NUM_DAC-1:0]                  load_event_i,
    output wire [`NUM_DAC-1:0]                  status_read_req_o,
    output reg  [`NUM_DAC-1:0]                  load_pulse_o,
    output reg  [`NUM_DAC-1:0]                  seq_irq_o,
    output reg  [`NUM_DAC-1:0]                  alert_irq_o,
    output reg  [`NUM_DAC-1:0]                  load_irq_o,
    output reg  [2*`NUM_DAC-1:0]                mode_o
);

    // Write and read channel state
    reg  [`ADDR_W-1:0]          aw_addr_reg;
    reg                         aw_full_reg;
    reg  [31:0]                 w_data_reg;
    reg  [3:0]                  w_strb_reg;
    reg                         w_full_reg;
    wire                        aw_take;
    wire                        w_take;
    wire                        do_write;
    wire                        aw_full_next;
    wire                        w_full_next;
    wire                        bvalid_next;
    wire                        ar_take;
    wire                        rvalid_next;

    // Register file state
    reg  [`TIMER_W-1:0]         timer_reg;
    reg  [`TICK_CNT_W-1:0]      div_reg;
    reg                         tick_reg;
    reg  [`NUM_DAC-1:0]         glb_done_reg;
    reg  [31:0]                 rd_word;
    reg                         rd_hit;
    wire [`CTRL_W-1:0]          wr_mask;
    wire [2:0]                  wr_sel;
    wire [2:0]                  wr_idx;
    wire                        wr_timer;
    wire [2:0]                  rd_sel;
    wire [2:0]                  rd_idx;
    wire [`NUM_DAC*`CTRL_W-1:0] ctrl_all;
    wire [`NUM_DAC*`STAT_W-1:0] stat_all;
    wire [`NUM_DAC-1:0]         glb_member;
    wire [`NUM_DAC-1:0]         glb_seen;
    wire                        glb_all_done;
    wire [`NUM_DAC-1:0]         load_next;
    wire [`NUM_DAC-1:0]         seq_irq_next;
    wire [`NUM_DAC-1:0]         alert_irq_next;
    wire [`NUM_DAC-1:0]         load_irq_next;
    wire [2*`NUM_DAC-1:0]       mode_next;

    // Address and data are held until both are in, so their order does not matter
    assign aw_take      = s_axi_awvalid_i && s_axi_awready_o;
    assign w_take       = s_axi_wvalid_i && s_axi_wready_o;
    assign do_write     = aw_full_reg && w_full_reg && !s_axi_bvalid_o;
    assign aw_full_next = (aw_full_reg || aw_take) && !do_write;
    assign w_full_next  = (w_full_reg || w_take) && !do_write;
    assign bvalid_next  = do_write || (s_axi_bvalid_o && !s_axi_bready_i);
    assign ar_take      = s_axi_arvalid_i && s_axi_arready_o;
    assign rvalid_next  = ar_take || (s_axi_rvalid_o && !s_axi_rready_i);

    assign wr_sel   = aw_addr_reg[7:5];
    assign wr_idx   = aw_addr_reg[4:2];
    assign wr_timer = do_write && (aw_addr_reg[7:2] == `TIMER_ADDR >> 2);
    assign rd_sel   = s_axi_araddr_i[7:5];
    assign rd_idx   = s_axi_araddr_i[4:2];
    // Byte lane 0 holds bits 7:0, lane 1 holds bits 9:8
    assign wr_mask  = {{2{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};

    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            aw_addr_reg     <= {`ADDR_W{1'b0}};
            aw_full_reg     <= 1'b0;
            w_data_reg      <= 32'h00000000;
            w_strb_reg      <= 4'h0;
            w_full_reg      <= 1'b0;
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o  <= 1'b0;
            s_axi_bvalid_o  <= 1'b0;
            s_axi_bresp_o   <= `RESP_OKAY;
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b0;
            s_axi_rdata_o   <= 32'h00000000;
            s_axi_rresp_o   <= `RESP_OKAY;
        end
        else
        begin
            if (aw_take)
            begin
                aw_addr_reg <= s_axi_awaddr_i;
            end
            if (w_take)
            begin
                w_data_reg <= s_axi_wdata_i;
                w_strb_reg <= s_axi_wstrb_i;
            end
            aw_full_reg     <= aw_full_next;
            w_full_reg      <= w_full_next;
            s_axi_awready_o <= !aw_full_next && !bvalid_next;
            s_axi_wready_o  <= !w_full_next && !bvalid_next;
            s_axi_bvalid_o  <= bvalid_next;
            if (do_write)
            begin
                s_axi_bresp_o <= ((wr_sel == `CTRL_SEL) || wr_timer) ? `RESP_OKAY : `RESP_SLVERR;
            end
            s_axi_rvalid_o  <= rvalid_next;
            s_axi_arready_o <= !rvalid_next;
            if (ar_take)
            begin
                s_axi_rdata_o <= rd_word;
                s_axi_rresp_o <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
            end
        end
    end

    // Unused high bits and unmapped words read as zero
    always @*
    begin
        rd_word = 32'h00000000;
        rd_hit  = 1'b1;
        if (rd_sel == `CTRL_SEL)
        begin
            rd_word[`CTRL_W-1:0] = ctrl_all[rd_idx*`CTRL_W +: `CTRL_W];
        end
        else if (rd_sel == `STAT_SEL)
        begin
            rd_word[`STAT_W-1:0] = stat_all[rd_idx*`STAT_W +: `STAT_W];
        end
        else if (s_axi_araddr_i[7:2] == `TIMER_ADDR >> 2)
        begin
            rd_word[`TIMER_W-1:0] = timer_reg;
        end
        else
        begin
            rd_hit = 1'b0;
        end
    end

    // Auto status timer, 1 us units
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            timer_reg <= `TIMER_RESET;
        end
        else if (wr_timer)
        begin
            if (w_strb_reg[0])
            begin
                timer_reg[7:0] <= w_data_reg[7:0];
            end
            if (w_strb_reg[1])
            begin
                timer_reg[15:8] <= w_data_reg[15:8];
            end
        end
    end

    // Microsecond enable shared by all converters
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            div_reg  <= {`TICK_CNT_W{1'b0}};
            tick_reg <= 1'b0;
        end
        else if (div_reg == (`TICK_CYCLES - 1))
        begin
            div_reg  <= {`TICK_CNT_W{1'b0}};
            tick_reg <= 1'b1;
        end
        else
        begin
            div_reg  <= div_reg + 5'h01;
            tick_reg <= 1'b0;
        end
    end

    genvar g;
    generate
        for (g = 0; g < `NUM_DAC; g = g + 1)
        begin : dac
            wire [`CTRL_W-1:0] ctrl;
            wire               manual;

            dac_channel u_chan (
                .clk_i          (clk_i),
                .rst_n_i        (rst_n_i),
                .tick_i         (tick_reg),
                .wr_en_i        (do_write && (wr_sel == `CTRL_SEL) && (wr_idx == g)),
                .wr_data_i      (w_data_reg[`CTRL_W-1:0]),
                .wr_mask_i      (wr_mask),
                .timer_period_i (timer_reg),
                .update_i       (dac_update_i[g]),
                .status_done_i  (status_done_i[g]),
                .status_data_i  (status_data_i[g*`STAT_DATA_W +: `STAT_DATA_W]),
                .ctrl_o         (ctrl),
                .status_o       (stat_all[g*`STAT_W +: `STAT_W]),
                .status_req_o   (status_read_req_o[g])
            );

            assign ctrl_all[g*`CTRL_W +: `CTRL_W] = ctrl;
            assign manual        = (ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO] == `MODE_MANUAL);
            assign glb_member[g] = manual && ctrl[`CTRL_GLM_BIT];
            assign glb_seen[g]   = glb_done_reg[g] || transfer_done_i[g];
            // Standalone loads at once, global members wait for the whole group
            assign load_next[g]  = manual && (ctrl[`CTRL_GLM_BIT] ? glb_all_done
                                                                  : transfer_done_i[g]);

            assign seq_irq_next[g]     = seq_event_i[g] && ctrl[`CTRL_SEQ_BIT];
            assign alert_irq_next[g]   = alert_event_i[g] && ctrl[`CTRL_ALERT_BIT];
            assign load_irq_next[g]    = load_event_i[g] && ctrl[`CTRL_LOAD_BIT];
            assign mode_next[2*g +: 2] = ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO];
        end
    endgenerate

    // One process drives each output vector, so no bit has a second driver
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            seq_irq_o    <= {`NUM_DAC{1'b0}};
            alert_irq_o  <= {`NUM_DAC{1'b0}};
            load_irq_o   <= {`NUM_DAC{1'b0}};
            load_pulse_o <= {`NUM_DAC{1'b0}};
            mode_o       <= {(2*`NUM_DAC){1'b0}};
        end
        else
        begin
            seq_irq_o    <= seq_irq_next;
            alert_irq_o  <= alert_irq_next;
            load_irq_o   <= load_irq_next;
            load_pulse_o <= load_next;
            mode_o       <= mode_next;
        end
    end

    assign glb_all_done = (glb_member != {`NUM_DAC{1'b0}}) &&
                          ((glb_seen & glb_member) == glb_member);

    // Completion flags of global members; leaving the group drops its flag
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            glb_done_reg <= {`NUM_DAC{1'b0}};
        end
        else if (glb_all_done)
        begin
            glb_done_reg <= {`NUM_DAC{1'b0}};
        end
        else
        begin
            glb_done_reg <= glb_seen & glb_member;
        end
    end

endmodule

// ===== verification/qdac_ctrl_monitor.sv
// Port-level assertions for the converter control register bank
`timescale 1ns/1ps
`include "qdac_ctrl_defs.vh"
module qdac_ctrl_monitor (
    input logic                 clk_i,
    input logic                 rst_n_i,
    input logic                 s_axi_awvalid_i,
    input logic                 s_axi_awready_o,
    input logic                 s_axi_wvalid_i,
    input logic                 s_axi_wready_o,
    input logic                 s_axi_bvalid_o,
    input logic                 s_axi_arvalid_i,
    input logic                 s_axi_arready_o,
    input logic                 s_axi_rvalid_o,
    input logic [`NUM_DAC-1:0]  transfer_done_i,
    input logic [`NUM_DAC-1:0]  status_done_i,
    input logic [`NUM_DAC-1:0]  seq_event_i,
    input logic [`NUM_DAC-1:0]  alert_event_i,
    input logic [`NUM_DAC-1:0]  load_event_i,
    input logic [`NUM_DAC-1:0]  status_read_req_o,
    input logic [`NUM_DAC-1:0]  load_pulse_o,
    input logic [`NUM_DAC-1:0]  seq_irq_o,
    input logic [`NUM_DAC-1:0]  alert_irq_o,
    input logic [`NUM_DAC-1:0]  load_irq_o,
    input logic [2*`NUM_DAC-1:0] mode_o
);
    logic [7:0] man;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    always_comb
    begin
        for (int i = 0; i < 8; i++)
            man[i] = (mode_o[2*i +: 2] == `MODE_MANUAL);
    end
    a_seq_gate:
        assert property ((seq_irq_o & ~$past(seq_event_i)) == 8'h00) else $error("seq irq without event");
    a_alert_gate:
        assert property ((alert_irq_o & ~$past(alert_event_i)) == 8'h00) else $error("alert irq without event");
    a_load_gate:
        assert property ((load_irq_o & ~$past(load_event_i)) == 8'h00) else $error("load irq without event");
    a_load_cause:
        assert property (load_pulse_o != 8'h00 |-> ($past(transfer_done_i) | $past(transfer_done_i, 2)) != 8'h00)
        else $error("load pulse without transfer");
    a_load_manual_only:
        assert property ((load_pulse_o & ~man) == 8'h00) else $error("load pulse outside manual mode");
    a_req_release:
        assert property (($past(status_read_req_o) & ~status_read_req_o & ~$past(status_done_i)) == 8'h00)
        else $error("status request dropped before done");
    a_read_answer:
        assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o) else $error("read answer late");
    a_write_answer:
        assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o |-> ##2 s_axi_bvalid_o)
        else $error("write answer late");
    cover property (load_pulse_o == 8'hC0);
    cover property ($rose(status_read_req_o[2]));
    cover property (seq_irq_o != 8'h00);
endmodule
bind quad_dac_control_register qdac_ctrl_monitor mon (.*);

// ===== verification/qdac_partner.sv
// Behavioural converter side answering status read requests
`timescale 1ns/1ps
module qdac_partner (
    input  logic        clk_i,
    input  logic        rst_n_i,
    input  logic        slow_i,
    input  logic [7:0]  req_i,
    output logic [7:0]  done_o,
    output logic [79:0] data_o
);
    logic [3:0] wait_cnt [8];
    logic [9:0] idle_pat;
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            done_o <= 8'h00;
            data_o <= '0;
            idle_pat <= 10'h000;
            for (int i = 0; i < 8; i++)
                wait_cnt[i] <= 4'h0;
        end
        else
        begin
            idle_pat <= idle_pat + 10'h001;
            for (int i = 0; i < 8; i++)
            begin
                done_o[i] <= 1'b0;
                // Outside an answer the word keeps moving, so a stale sample cannot pass
                data_o[10*i +: 10] <= ~idle_pat;
                if (done_o[i])
                    wait_cnt[i] <= 4'h0;
                else if (req_i[i] && wait_cnt[i] == (slow_i ? 4'hB : 4'h1))
                begin
                    done_o[i] <= 1'b1;
                    data_o[10*i +: 10] <= 10'h100 | 10'(i);
                end
                else if (req_i[i])
                    wait_cnt[i] <= wait_cnt[i] + 4'h1;
            end
        end
    end
endmodule

// ===== verification/tb_quad_dac_control_register.sv
// Self-checking bench for the converter control register bank
`timescale 1ns/1ps
`include "qdac_ctrl_defs.vh"
module tb_quad_dac_control_register;
    logic        clk_i, rst_n_i, slow;
    logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i;
    logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
    logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
    logic        s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o, s_axi_bready_i;
    logic        s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i;
    logic [7:0]  dac_update_i, transfer_done_i, status_done_i, seq_event_i;
    logic [7:0]  status_read_req_o, load_pulse_o, seq_irq_o, alert_irq_o, load_irq_o, acc;
    logic [79:0] status_data_i;
    logic [15:0] mode_o;
    wire  [7:0]  alert_event_i = seq_event_i;
    wire  [7:0]  load_event_i = seq_event_i;
    wire  [3:0]  s_axi_wstrb_i = 4'hF;
    integer      err_count, check_count, cyc, i, n;

    quad_dac_control_register uut (.*);
    qdac_partner partner (.clk_i, .rst_n_i, .slow_i(slow), .req_i(status_read_req_o), .done_o(status_done_i),
                          .data_o(status_data_i));

    initial
    begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    always @(posedge clk_i)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            err_count = err_count + 1;
            finish_test;
        end
    end

    task chk(input [31:0] got, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp)
            begin
                $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
                err_count = err_count + 1;
            end
        end
    endtask

    task finish_test;
        begin
            $display("Checks %0d, mismatches %0d", check_count, err_count);
            if (err_count == 0 && check_count > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask

    task wr(input [7:0] a, input [31:0] d, input [1:0] er);
        begin
            @(posedge clk_i);
            s_axi_awaddr_i <= a;
            s_axi_wdata_i <= d;
            s_axi_awvalid_i <= 1'b1;
            s_axi_wvalid_i <= 1'b1;
            s_axi_bready_i <= 1'b1;
            do
            begin
                @(posedge clk_i);
                if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
                if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
            end
            while (s_axi_bvalid_o !== 1'b1);
            s_axi_bready_i <= 1'b0;
            chk(s_axi_bresp_o, er);
        end
    endtask

    task rdr(input [7:0] a, input [31:0] ed, input [1:0] er);
        begin
            @(posedge clk_i);
            s_axi_araddr_i <= a;
            s_axi_arvalid_i <= 1'b1;
            s_axi_rready_i <= 1'b1;
            do
            begin
                @(posedge clk_i);
                if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
            end
            while (s_axi_rvalid_o !== 1'b1);
            s_axi_rready_i <= 1'b0;
            chk(s_axi_rdata_o, ed);
            chk(s_axi_rresp_o, er);
        end
    endtask

    // Rising edges of one request line over 400 cycles
    task rises(input integer b, output integer c);
        logic p;
        begin
            c = 0;
            p = status_read_req_o[b];
            repeat (400)
            begin
                @(negedge clk_i);
                if (status_read_req_o[b] && !p) c = c + 1;
                p = status_read_req_o[b];
            end
        end
    endtask

    task td(input [7:0] v, input [7:0] exp);
        begin
            @(posedge clk_i);
            transfer_done_i <= v;
            @(posedge clk_i);
            transfer_done_i <= 8'h00;
            acc = 8'h00;
            repeat (3) @(negedge clk_i) acc = acc | load_pulse_o;
            chk(acc, exp);
        end
    endtask

    initial
    begin
        {cyc, err_count, check_count} = '0;
        {rst_n_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = '0;
        {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i, dac_update_i, transfer_done_i, seq_event_i} = '0;
        slow = 1'b1;
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        for (i = 0; i < 8; i = i + 1)
            rdr(8'(8'h20 + 4 * i), 32'h0, 2'h0);
        rdr(8'h60, 32'h3E8, 2'h0);
        $display("reset values done");
        wr(8'h20, 32'hFFFFFFFF, 2'h0);
        @(negedge clk_i) chk(status_read_req_o[0], 1'b0);
        rdr(8'h20, 32'h1BB, 2'h0);
        rdr(8'h40, 32'h0, 2'h0);
        for (i = 0; i < 4; i = i + 1)
        begin
            wr(8'h24, i, 2'h0);
            @(negedge clk_i) chk(mode_o[3:2], i);
        end
        rdr(8'h24, 32'h3, 2'h0);
        wr(8'h10, 32'h1, 2'h2);
        rdr(8'h10, 32'h0, 2'h2);
        wr(8'h44, 32'h1, 2'h2);
        $display("fields and map done");
        wr(8'h28, 32'h201, 2'h0);
        @(negedge clk_i) chk(status_read_req_o[2], 1'b1);
        rdr(8'h28, 32'h001, 2'h0);
        while (status_read_req_o[2] !== 1'b0) @(negedge clk_i);
        rdr(8'h48, 32'h502, 2'h0);
        wr(8'h28, 32'h201, 2'h0);
        rdr(8'h48, 32'h102, 2'h0);
        while (status_read_req_o[2] !== 1'b0) @(negedge clk_i);
        wr(8'h28, 32'h202, 2'h0);
        repeat (3) @(negedge clk_i);
        chk(status_read_req_o[2], 1'b0);
        rdr(8'h48, 32'h502, 2'h0);
        $display("status read done");
        for (i = 0; i < 3; i = i + 1)
        begin
            wr(8'h2C, 32'h20 >> i, 2'h0);
            @(posedge clk_i) seq_event_i <= 8'h18;
            @(posedge clk_i) seq_event_i <= 8'h00;
            @(negedge clk_i) chk(seq_irq_o, i == 0 ? 8'h08 : 8'h00);
            chk(alert_irq_o, i == 1 ? 8'h08 : 8'h00);
            chk(load_irq_o, i == 2 ? 8'h08 : 8'h00);
        end
        $display("interrupt gates done");
        wr(8'h34, 32'h001, 2'h0);
        wr(8'h38, 32'h101, 2'h0);
        wr(8'h3C, 32'h101, 2'h0);
        td(8'h21, 8'h20);
        td(8'h40, 8'h00);
        td(8'h80, 8'hC0);
        $display("load done");
        slow = 1'b0;
        wr(8'h60, 32'h2, 2'h0);
        wr(8'h24, 32'h081, 2'h0);
        rises(1, n);
        chk(n >= 9 && n <= 11, 1'b1);
        wr(8'h24, 32'h001, 2'h0);
        rises(1, n);
        chk(n, 0);
        wr(8'h28, 32'h082, 2'h0);
        @(posedge clk_i) dac_update_i <= 8'h04;
        @(posedge clk_i) dac_update_i <= 8'h00;
        n = 0;
        while (status_read_req_o[2] !== 1'b1 && n < 400) @(negedge clk_i) n = n + 1;
        chk(n >= 179 && n <= 221, 1'b1);
        rises(2, n);
        chk(n, 0);
        $display("auto read done");
        finish_test;
    end
endmodule
